//--- include/lpm_pkg.sv
package lpm_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TIMED_ACCESS_UNLOCK_ADDR = 8'hC7; // unlock register
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h80; // idle / stop request
  localparam logic [7:0] RING_AND_BANDGAP_CONTROL_ADDR = 8'h81; // ring and band-gap
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h82; // watchdog control
  localparam logic [7:0] PROGRAM_MEMORY_SIZE_ADDR = 8'h83; // on-chip program size
  localparam logic [7:0] POWER_MANAGEMENT_REGISTER_ADDR = 8'h84; // strobe and divider
  // ****************************************
  // unlock sequence values
  // ****************************************
  localparam logic [7:0] UNLOCK_FIRST = 8'hAA; // first unlock byte
  localparam logic [7:0] UNLOCK_SECOND = 8'h55; // second unlock byte
  // ****************************************
  // field positions
  // ****************************************
  localparam int IDLE_BIT = 0; // power_control
  localparam int STOP_BIT = 1; // power_control
  localparam int BANDGAP_KEEP_BIT = 0; // ring_and_bandgap_control
  localparam int RING_SELECT_BIT = 1; // ring_and_bandgap_control
  localparam int RING_FLAG_BIT = 2; // ring_and_bandgap_control, read only
  localparam int POR_FLAG_BIT = 6; // watchdog_control
  localparam int WD_IRQ_FLAG_BIT = 3; // watchdog_control
  localparam int WD_RESET_EN_BIT = 1; // watchdog_control
  localparam int WD_RESTART_BIT = 0; // watchdog_control
  localparam int STROBE_SUPPRESS_BIT = 2; // power_management_register
  localparam int DIVIDED_CLOCK_BIT = 3; // power_management_register
  // ****************************************
  // protection masks and reset values
  // ****************************************
  localparam logic [7:0] WATCHDOG_PROTECTED_MASK = 8'h4B; // bits 6,3,1,0
  localparam logic [7:0] RING_PROTECTED_MASK = 8'h01; // band-gap keep
  localparam logic [7:0] SIZE_PROTECTED_MASK = 8'h07; // size bits 2..0
  localparam logic [7:0] RING_WRITE_MASK = 8'h03; // writable ring bits
  localparam logic [7:0] WATCHDOG_RESET = 8'h00; // watchdog control at reset
  localparam logic [7:0] SIZE_RESET = 8'h07; // full on-chip program size
  localparam logic [7:0] POWER_MANAGEMENT_RESET = 8'h00; // strobe not suppressed
  // ****************************************
  // timing
  // ****************************************
  localparam int UNLOCK_WINDOW_CYCLES = 3; // unlock window length in cycles
  localparam int RING_HANDOVER_XTAL_CLOCKS = 65536; // crystal clocks before handover
  localparam int STROBE_DIVIDE = 4; // strobe period in crystal clocks
endpackage

//--- testbench/low_power_mode_control_test.sv
`timescale 1ns/100ps
module low_power_mode_control_test;
  import lpm_pkg::*;
  // ****
  // stimulus and observed signals
  // ****
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_done = 1'b0;
  logic irq_taken = 1'b0, ext_irq = 1'b0, power_fail_event = 1'b0, offchip = 1'b0;
  logic por_set = 1'b0, wd_irq_set = 1'b0, xtick = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, wd_control;
  // short handover count keeps the run brief
  localparam int HANDOVER_TEST = 8;
  logic [2:0] size;
  logic halted, stopped, bg_on, pf_wake, ring_flag, window, divided, strobe;
  int n_fail = 0, tests_run = 0, cnt;
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  low_power_mode_control #(.HANDOVER_CLOCKS(HANDOVER_TEST)) i_dut (.core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_done(instr_done), .irq_taken(irq_taken),
    .ext_irq(ext_irq), .power_fail_event(power_fail_event), .xtal_tick(xtick),
    .offchip_data_access(offchip), .por_flag_set(por_set), .wd_irq_flag_set(wd_irq_set),
    .cpu_halted(halted), .clocks_stopped(stopped), .bandgap_on(bg_on),
    .power_fail_wake(pf_wake), .ring_clock_active_flag(ring_flag),
    .unlock_window_open(window), .watchdog_control(wd_control), .program_memory_size(size),
    .divided_clock_mode(divided), .address_latch_strobe(strobe));
  // ****
  // bus and compare tasks
  // ****
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task check1(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  // write strobe stays up so writes can run back to back
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  // read data are looked at in the single answer cycle
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check("reg_rdata", reg_rdata, e);
    @(posedge core_clk);
  endtask
  task unlock;
    wr(TIMED_ACCESS_UNLOCK_ADDR, UNLOCK_FIRST);
    wr(TIMED_ACCESS_UNLOCK_ADDR, UNLOCK_SECOND);
  endtask
  // write the stop bit and end the instruction
  task enter_stop;
    wr(POWER_CONTROL_ADDR, 8'h02);
    idle(1);
    instr_done <= 1'b1;
    @(posedge core_clk);
    instr_done <= 1'b0;
    @(negedge core_clk);
  endtask
  task count_strobe(output int c);
    c = 0;
    repeat (16)
    begin
      @(negedge core_clk);
      c += int'(strobe === 1'b1);
    end
    @(posedge core_clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****
  // test sequence
  // ****
  initial
  begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(POWER_CONTROL_ADDR, 8'h00);
    rd(RING_AND_BANDGAP_CONTROL_ADDR, 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, WATCHDOG_RESET);
    rd(PROGRAM_MEMORY_SIZE_ADDR, SIZE_RESET);
    rd(POWER_MANAGEMENT_REGISTER_ADDR, POWER_MANAGEMENT_RESET);
    rd(8'h90, 8'h00);
    $display("reset values done");
    // protected writes without unlock are dropped
    wr(WATCHDOG_CONTROL_ADDR, 8'hFF);
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h00);
    wr(RING_AND_BANDGAP_CONTROL_ADDR, 8'h01);
    idle(1);
    check("watchdog", wd_control & WATCHDOG_PROTECTED_MASK, 8'h00);
    check("size", {5'h00, size}, 8'h07);
    rd(RING_AND_BANDGAP_CONTROL_ADDR, 8'h00);
    por_set <= 1'b1;
    wd_irq_set <= 1'b1;
    @(posedge core_clk);
    por_set <= 1'b0;
    wd_irq_set <= 1'b0;
    @(negedge core_clk);
    check("watchdog flags", wd_control & 8'h48, 8'h48);
    @(posedge core_clk);
    // one protected write per window
    unlock;
    wr(WATCHDOG_CONTROL_ADDR, 8'hFF);
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h00);
    idle(1);
    check("watchdog enable", wd_control & 8'h02, 8'h02);
    check("size", {5'h00, size}, 8'h07);
    unlock;
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h02);
    idle(1);
    check("size", {5'h00, size}, 8'h02);
    // a wrong second byte restarts the detector
    wr(TIMED_ACCESS_UNLOCK_ADDR, UNLOCK_FIRST);
    wr(TIMED_ACCESS_UNLOCK_ADDR, 8'h12);
    wr(TIMED_ACCESS_UNLOCK_ADDR, UNLOCK_SECOND);
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h05);
    idle(1);
    check("size", {5'h00, size}, 8'h02);
    // window still open in its third cycle, closed in the fourth
    unlock;
    idle(2);
    @(negedge core_clk);
    check1("window", window, 1'b1);
    @(posedge core_clk);
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h05);
    idle(1);
    check("size", {5'h00, size}, 8'h02);
    unlock;
    idle(2);
    wr(PROGRAM_MEMORY_SIZE_ADDR, 8'h05);
    idle(1);
    check("size", {5'h00, size}, 8'h05);
    unlock;
    wr(RING_AND_BANDGAP_CONTROL_ADDR, 8'h03);
    rd(RING_AND_BANDGAP_CONTROL_ADDR, 8'h03);
    $display("timed access done");
    // stop with reference kept and ring restart
    enter_stop;
    check1("stopped", stopped, 1'b1);
    check1("halted", halted, 1'b1);
    check1("bandgap", bg_on, 1'b1);
    @(posedge core_clk);
    irq_taken <= 1'b1;
    @(posedge core_clk);
    irq_taken <= 1'b0;
    @(negedge core_clk);
    check1("stopped", stopped, 1'b1);
    @(posedge core_clk);
    power_fail_event <= 1'b1;
    @(negedge core_clk);
    check1("pf wake", pf_wake, 1'b1);
    @(posedge core_clk);
    power_fail_event <= 1'b0;
    xtick <= 1'b0;
    @(negedge core_clk);
    check1("stopped", stopped, 1'b0);
    check1("ring flag", ring_flag, 1'b1);
    @(posedge core_clk);
    rd(RING_AND_BANDGAP_CONTROL_ADDR, 8'h07);
    // handover counts crystal ticks, not core cycles
    idle(2 * HANDOVER_TEST);
    @(negedge core_clk);
    check1("ring held", ring_flag, 1'b1);
    @(posedge core_clk);
    xtick <= 1'b1;
    repeat (HANDOVER_TEST - 1) @(posedge core_clk);
    @(negedge core_clk);
    check1("ring early", ring_flag, 1'b1);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check1("handover", ring_flag, 1'b0);
    @(posedge core_clk);
    rd(RING_AND_BANDGAP_CONTROL_ADDR, 8'h03);
    // stop without reference, crystal restart
    unlock;
    wr(RING_AND_BANDGAP_CONTROL_ADDR, 8'h00);
    enter_stop;
    check1("bandgap", bg_on, 1'b0);
    @(posedge core_clk);
    power_fail_event <= 1'b1;
    @(posedge core_clk);
    power_fail_event <= 1'b0;
    @(negedge core_clk);
    check1("stopped", stopped, 1'b1);
    @(posedge core_clk);
    ext_irq <= 1'b1;
    @(posedge core_clk);
    ext_irq <= 1'b0;
    @(negedge core_clk);
    check1("stopped", stopped, 1'b0);
    check1("ring flag", ring_flag, 1'b0);
    check1("bandgap", bg_on, 1'b1);
    @(posedge core_clk);
    $display("stop done");
    // idle ends on a taken interrupt
    wr(POWER_CONTROL_ADDR, 8'h01);
    idle(1);
    @(negedge core_clk);
    check1("halted", halted, 1'b1);
    check1("stopped", stopped, 1'b0);
    @(posedge core_clk);
    irq_taken <= 1'b1;
    @(posedge core_clk);
    irq_taken <= 1'b0;
    @(negedge core_clk);
    check1("halted", halted, 1'b0);
    @(posedge core_clk);
    $display("idle done");
    // strobe rate, suppression and off-chip access
    count_strobe(cnt);
    check("strobe count", cnt[7:0], 8'h04);
    wr(POWER_MANAGEMENT_REGISTER_ADDR, 8'h0C);
    idle(1);
    count_strobe(cnt);
    check("strobe count", cnt[7:0], 8'h00);
    check1("divided", divided, 1'b1);
    offchip <= 1'b1;
    // let the off-chip level reach the strobe before counting
    @(posedge core_clk);
    count_strobe(cnt);
    check("strobe count", cnt[7:0], 8'h04);
    // second reset in mid run
    offchip <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    check("size", {5'h00, size}, 8'h07);
    check1("divided", divided, 1'b0);
    $display("strobe and reset done");
    end_of_test;
  end
endmodule

//--- testbench/lpm_sva.sv
`timescale 1ns/100ps
// ****
// port checker for the low power block
// ****
module lpm_sva
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic ext_irq,
  input wire logic power_fail_event,
  input wire logic cpu_halted,
  input wire logic clocks_stopped,
  input wire logic bandgap_on,
  input wire logic power_fail_wake,
  input wire logic ring_clock_active_flag,
  input wire logic unlock_window_open,
  input wire logic [7:0] watchdog_control,
  input wire logic [2:0] program_memory_size,
  input wire logic address_latch_strobe
);
  import lpm_pkg::*;
  // one clock domain, so clock and reset are shared
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  stop_entry_a: assert property ($rose(clocks_stopped) |-> $past(instr_done))
    else $error("stop began without an instruction end");
  stop_halts_a: assert property (clocks_stopped |-> cpu_halted)
    else $error("stopped but not halted");
  ext_wake_a: assert property (clocks_stopped && ext_irq |=> !clocks_stopped)
    else $error("external interrupt did not end stop");
  stop_holds_a: assert property (clocks_stopped && !ext_irq && !power_fail_wake
    |=> clocks_stopped)
    else $error("stop ended without a wake source");
  pf_wake_a: assert property (clocks_stopped && bandgap_on && power_fail_event
    |=> !clocks_stopped)
    else $error("power failure with kept reference did not end stop");
  ref_running_a: assert property (!clocks_stopped |-> bandgap_on)
    else $error("reference off while running");
  ring_start_a: assert property ($rose(ring_clock_active_flag)
    |-> $past(clocks_stopped) && !clocks_stopped)
    else $error("ring flag rose without a stop exit");
  window_cause_a: assert property ($rose(unlock_window_open) |-> $past(reg_wr
    && reg_addr == TIMED_ACCESS_UNLOCK_ADDR && reg_wdata == UNLOCK_SECOND))
    else $error("window opened without the second unlock byte");
  window_len_a: assert property (unlock_window_open [*3] |=> !unlock_window_open)
    else $error("window open longer than three cycles");
  size_guard_a: assert property (!$past(unlock_window_open)
    |-> $stable(program_memory_size) && $stable(watchdog_control[WD_RESET_EN_BIT]))
    else $error("protected bit changed outside window");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  strobe_rate_a: assert property ($rose(address_latch_strobe)
    |=> !address_latch_strobe [*3])
    else $error("strobe faster than one in four");
endmodule
bind low_power_mode_control lpm_sva i_sva (.core_clk(core_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instr_done(instr_done), .ext_irq(ext_irq),
  .power_fail_event(power_fail_event), .cpu_halted(cpu_halted),
  .clocks_stopped(clocks_stopped), .bandgap_on(bandgap_on),
  .power_fail_wake(power_fail_wake), .ring_clock_active_flag(ring_clock_active_flag),
  .unlock_window_open(unlock_window_open), .watchdog_control(watchdog_control),
  .program_memory_size(program_memory_size), .address_latch_strobe(address_latch_strobe));

//--- verilog/low_power_mode_control.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module low_power_mode_control
#(
  parameter int HANDOVER_CLOCKS = lpm_pkg::RING_HANDOVER_XTAL_CLOCKS
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic irq_taken,
  input wire logic ext_irq,
  input wire logic power_fail_event,
  input wire logic xtal_tick,
  input wire logic offchip_data_access,
  input wire logic por_flag_set,
  input wire logic wd_irq_flag_set,
  output logic cpu_halted,
  output logic clocks_stopped,
  output logic bandgap_on,
  output logic power_fail_wake,
  output logic ring_clock_active_flag,
  output logic unlock_window_open,
  output logic [7:0] watchdog_control,
  output logic [2:0] program_memory_size,
  output logic divided_clock_mode,
  output logic address_latch_strobe
);
  import lpm_pkg::*;

  initial
  begin
    if (HANDOVER_CLOCKS < 1)
      $error("handover count must be at least one");
  end

  // ****************************************
  // declarations
  // ****************************************
  typedef enum {WAIT_FIRST, GOT_FIRST, WINDOW_OPEN} unlock_e;

  unlock_e unlock_state_r; // unlock sequence state
  logic [1:0] window_count_r; // cycles left in window
  logic idle_r; // idle mode active
  logic stop_pending_r; // stop requested, waiting for instruction end
  logic stop_r; // stop mode active
  logic bandgap_keep_r; // keep reference on in stop
  logic ring_select_r; // restart from ring oscillator
  logic ring_active_r; // ring oscillator is the clock
  logic [7:0] watchdog_r; // watchdog control image
  logic [2:0] size_r; // program memory size bits
  logic strobe_suppress_r; // suppress strobe on-chip
  logic divided_r; // divided-clock mode bit
  logic [1:0] strobe_phase_r; // crystal tick phase for strobe
  logic strobe_r; // registered strobe
  logic [7:0] rdata_r; // read data register
  logic ring_done; // handover count reached
  logic unlock_write; // write to the unlock register
  logic window; // protected write allowed this cycle
  logic prot_write; // a protected bit write consumes the window
  logic wake_from_stop; // stop exit event

  // ****************************************
  // helpers
  // ****************************************
  // true when a write hits the given address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = reg_wr && (a == target);
  endfunction

  // merge new data into protected bits only when allowed
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] pmask, input logic ok);
    merge = ok ? nw : ((old & pmask) | (nw & ~pmask));
  endfunction

  assign unlock_write = hit(reg_addr, TIMED_ACCESS_UNLOCK_ADDR);
  assign window = (unlock_state_r == WINDOW_OPEN);
  assign prot_write = window && (hit(reg_addr, WATCHDOG_CONTROL_ADDR)
                      || hit(reg_addr, RING_AND_BANDGAP_CONTROL_ADDR)
                      || hit(reg_addr, PROGRAM_MEMORY_SIZE_ADDR));
  // band-gap kept on lets a power failure wake the part
  assign power_fail_wake = stop_r && bandgap_keep_r && power_fail_event;
  assign wake_from_stop = stop_r && (ext_irq || power_fail_wake);

  // ****************************************
  // timed access unlock
  // ****************************************
  // any other write between the two bytes restarts the sequence
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      unlock_state_r <= WAIT_FIRST;
      window_count_r <= 2'h0;
    end
    else
    begin
      unique case (unlock_state_r)
        WAIT_FIRST:
        begin
          if (unlock_write && reg_wdata == UNLOCK_FIRST)
            unlock_state_r <= GOT_FIRST;
        end
        GOT_FIRST:
        begin
          if (unlock_write && reg_wdata == UNLOCK_SECOND)
          begin
            unlock_state_r <= WINDOW_OPEN;
            window_count_r <= 2'(UNLOCK_WINDOW_CYCLES - 1);
          end
          else if (unlock_write && reg_wdata == UNLOCK_FIRST)
            unlock_state_r <= GOT_FIRST; // a fresh first byte restarts
          else if (reg_wr)
            unlock_state_r <= WAIT_FIRST;
        end
        WINDOW_OPEN:
        begin
          // one protected write per unlock, or the window times out
          if (prot_write || window_count_r == 2'h0)
            unlock_state_r <= WAIT_FIRST;
          else
            window_count_r <= window_count_r - 2'h1;
          if (unlock_write && reg_wdata == UNLOCK_FIRST)
            unlock_state_r <= GOT_FIRST;
        end
      endcase
    end
  end

  assign unlock_window_open = window;

  // ****************************************
  // idle mode
  // ****************************************
  // idle holds until any interrupt is taken
  always_ff @(posedge core_clk)
  begin
    if (srst)
      idle_r <= 1'b0;
    else if (irq_taken)
      idle_r <= 1'b0;
    else if (hit(reg_addr, POWER_CONTROL_ADDR) && reg_wdata[IDLE_BIT])
      idle_r <= 1'b1;
  end

  // ****************************************
  // stop mode
  // ****************************************
  // stop takes effect when the writing instruction completes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stop_pending_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      // a write that ends its own instruction stops at once, nothing is left pending
      if (hit(reg_addr, POWER_CONTROL_ADDR) && reg_wdata[STOP_BIT] && !instr_done)
        stop_pending_r <= 1'b1;
      else if (instr_done)
        stop_pending_r <= 1'b0;
      if (wake_from_stop)
        stop_r <= 1'b0;
      else if ((stop_pending_r || (hit(reg_addr, POWER_CONTROL_ADDR)
                && reg_wdata[STOP_BIT])) && instr_done)
        stop_r <= 1'b1;
    end
  end

  assign cpu_halted = idle_r || stop_r;
  assign clocks_stopped = stop_r;
  // reference follows the keep bit only while stopped
  assign bandgap_on = !stop_r || bandgap_keep_r;

  // ****************************************
  // ring and band-gap control
  // ****************************************
  // keep bit is protected, ring select is free
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bandgap_keep_r <= 1'b0;
      ring_select_r <= 1'b0;
    end
    else if (hit(reg_addr, RING_AND_BANDGAP_CONTROL_ADDR))
    begin
      ring_select_r <= reg_wdata[RING_SELECT_BIT];
      if (window)
        bandgap_keep_r <= reg_wdata[BANDGAP_KEEP_BIT];
    end
  end

  // ring becomes the clock on a stop exit with ring select set, crystal takes over later
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ring_active_r <= 1'b0;
    else if (wake_from_stop && ring_select_r)
      ring_active_r <= 1'b1;
    else if (ring_done)
      ring_active_r <= 1'b0;
  end

  xtal_tick_counter #(.TARGET(HANDOVER_CLOCKS)) u_handover
  (
    .core_clk(core_clk),
    .srst(srst),
    .run(ring_active_r),
    .tick(xtal_tick),
    .done(ring_done)
  );

  assign ring_clock_active_flag = ring_active_r;

  // ****************************************
  // watchdog control and program size
  // ****************************************
  // hardware set of a flag wins over a software clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      watchdog_r <= WATCHDOG_RESET;
    else
    begin
      if (hit(reg_addr, WATCHDOG_CONTROL_ADDR))
        watchdog_r <= merge(watchdog_r, reg_wdata, WATCHDOG_PROTECTED_MASK, window);
      if (por_flag_set)
        watchdog_r[POR_FLAG_BIT] <= 1'b1;
      if (wd_irq_flag_set)
        watchdog_r[WD_IRQ_FLAG_BIT] <= 1'b1;
    end
  end

  // all three size bits are protected
  always_ff @(posedge core_clk)
  begin
    if (srst)
      size_r <= SIZE_RESET[2:0];
    else if (hit(reg_addr, PROGRAM_MEMORY_SIZE_ADDR) && window)
      size_r <= reg_wdata[2:0];
  end

  assign watchdog_control = watchdog_r;
  assign program_memory_size = size_r;

  // ****************************************
  // power management register
  // ****************************************
  // strobe suppress and divided-clock mode are unprotected
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      strobe_suppress_r <= POWER_MANAGEMENT_RESET[STROBE_SUPPRESS_BIT];
      divided_r <= POWER_MANAGEMENT_RESET[DIVIDED_CLOCK_BIT];
    end
    else if (hit(reg_addr, POWER_MANAGEMENT_REGISTER_ADDR))
    begin
      strobe_suppress_r <= reg_wdata[STROBE_SUPPRESS_BIT];
      divided_r <= reg_wdata[DIVIDED_CLOCK_BIT];
    end
  end

  assign divided_clock_mode = divided_r;

  // ****************************************
  // address latch strobe
  // ****************************************
  // one high crystal clock in every four, held low when stopped or when suppressed without off-chip access
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      strobe_phase_r <= 2'h0;
      strobe_r <= 1'b0;
    end
    else if (stop_r)
      strobe_r <= 1'b0;
    else if (xtal_tick)
    begin
      strobe_phase_r <= 2'(strobe_phase_r + 2'h1);
      if (strobe_suppress_r && !offchip_data_access)
        strobe_r <= 1'b0;
      else
        strobe_r <= (strobe_phase_r == 2'(STROBE_DIVIDE - 1));
    end
  end

  assign address_latch_strobe = strobe_r;

  // ****************************************
  // register read
  // ****************************************
  // data stands the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge core_clk)
  begin
    if (srst || !reg_rd)
      rdata_r <= 8'h00;
    else
    begin
      unique case (reg_addr)
        POWER_CONTROL_ADDR:
          rdata_r <= {6'h00, stop_r, idle_r};
        RING_AND_BANDGAP_CONTROL_ADDR:
          rdata_r <= {5'h00, ring_active_r, ring_select_r, bandgap_keep_r};
        WATCHDOG_CONTROL_ADDR:
          rdata_r <= watchdog_r;
        PROGRAM_MEMORY_SIZE_ADDR:
          rdata_r <= {5'h00, size_r};
        POWER_MANAGEMENT_REGISTER_ADDR:
          rdata_r <= {4'h0, divided_r, strobe_suppress_r, 2'h0};
        default:
          rdata_r <= 8'h00; // unlock register is write only
      endcase
    end
  end

  assign reg_rdata = rdata_r;
endmodule

//--- verilog/xtal_tick_counter.sv
`timescale 1ns/100ps
// counts crystal ticks while enabled and flags when the target is reached
module xtal_tick_counter
#(
  parameter int TARGET = 65536
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  output logic done
);
  import lpm_pkg::*;

  localparam int W = $clog2(TARGET + 1);

  initial
  begin
    if (TARGET < 1)
      $error("target must be at least one");
  end

  logic [W-1:0] count_r; // ticks seen so far

  // ****************************************
  // counter
  // ****************************************
  // clears whenever not running so every start counts from zero
  always_ff @(posedge core_clk)
  begin
    if (srst || !run)
      count_r <= '0;
    else if (tick && !done)
      count_r <= count_r + W'(1);
  end

  assign done = run && (count_r == W'(TARGET));
endmodule
